// File: src/ppx_top.sv
/*
 * Page-2 control bank: transmit amplitude trims, energy-saving debug
 * controls with live status, and MAC-interface timing controls.
 * Assumes an AHB-Lite master on clk, status inputs from pins (synchronised
 * here) and MAC/line data already on clk.
 */
// What this block does
// R1: Page register selects page 2 at 0x0002
// R2: Gigabit trim bits 15:12, reset 0000
// R3: 100M trim bits 11:8, reset 0010
// R4: 10M trim bits 7:4, reset 1000
// R5: 10M energy trim bits 3:0, reset 1110
// R6: Bit 15 enables 10M energy-efficient mode
// R7: Bits 11:10 invert active-low LED outputs
// R8: Bits 8,7,6 report link, EEE status
// R9: Bit 5 allows forced gigabit without master/slave
// R10: Bit 4 forces generator LPI, ignores MAC
// R11: Bits 4:0 are debug only
// R12: Bit 3 blocks 100M transmit LPI
// R13: Bit 2 blocks 100M receive LPI
// R14: Bit 1 blocks gigabit transmit LPI
// R15: Bit 0 blocks gigabit receive LPI
// R16: Bit 15 enables fast link drop, not sticky
// R17: Bit 12 enables start-of-frame indication
// R18: Bit 7 reverses receive data lanes
// R19: Bit 3 reverses transmit data lanes
// R20: Clock delay codes, reset 000
// R21: Sticky fields survive software reset
`timescale 1ns/1ps
`default_nettype none

module ppx_top
	import ppx_pkg::*;
(
	input  wire logic        clk,             // 40 MHz clock
	input  wire logic        rst,             // Sync hardware reset
	input  wire logic        ce,              // Clock enable
	input  wire logic        hsel,            // AHB select
	input  wire logic [31:0] haddr,           // AHB address
	input  wire logic [1:0]  htrans,          // AHB transfer type
	input  wire logic        hwrite,          // AHB write
	input  wire logic [2:0]  hsize,           // AHB size
	input  wire logic [31:0] hwdata,          // AHB write data
	input  wire logic        hready,          // AHB bus ready
	output logic      [31:0] hrdata,          // AHB read data
	output logic             hreadyout,       // AHB slave ready
	output logic             hresp,           // AHB response
	input  wire logic        link_up_in,      // Link status pin
	input  wire logic        gig_eee_in,      // Gigabit EEE active pin
	input  wire logic        fe_eee_in,       // 100M EEE active pin
	input  wire logic [1:0]  speed_sel,       // 00 10M, 01 100M, 10 gigabit
	input  wire logic        mac_wide,        // MAC bus is 8 bits
	input  wire logic        mac_tx_lpi,      // MAC requests transmit LPI
	input  wire logic        mdi_rx_lpi,      // LPI received from line
	input  wire logic [7:0]  mac_txd,         // MAC transmit data
	input  wire logic [7:0]  line_rxd,        // Line receive data
	input  wire logic        gen_lpi_ok,      // Generator may send LPI
	input  wire logic [1:0]  led_raw,         // LED on requests
	input  wire logic        ctrl_speed_msb,  // Control register bit 6
	input  wire logic        ctrl_speed_lsb,  // Control register bit 13
	output logic      [3:0]  copper_line_driver_gig_trim, // Gigabit amplitude code
	output logic      [3:0]  copper_line_driver_fe_trim,  // 100M amplitude code
	output logic      [3:0]  copper_line_driver_te_trim,  // 10M amplitude code
	output logic      [3:0]  copper_line_driver_tee_trim, // 10M energy amplitude code
	output logic             te_eee_mode,     // 10M energy mode enable
	output logic      [1:0]  led_pin,         // LED pins
	output logic             force_gig_ok,    // Forced gigabit allowed
	output logic             mdi_tx_lpi,      // Send LPI on line
	output logic             mac_rx_lpi,      // Pass LPI to MAC
	output logic             ignore_mac_tx,   // Drop MAC transmit data
	output logic             fast_link_drop_alert_en, // Fast link drop enable
	output logic             sof_ind_en,      // Start-of-frame indication enable
	output logic      [2:0]  rx_clk_dly,      // Receive clock delay code
	output logic      [2:0]  tx_clk_dly,      // Transmit clock delay code
	output logic      [7:0]  mac_rxd,         // Receive data to MAC
	output logic      [7:0]  line_txd         // Transmit data to line
);

	logic [15:0] page_q;
	logic [15:0] trim_q;
	logic [15:0] eee_q;
	logic [15:0] mac_q;
	logic [2:0]  sync1_q;
	logic [2:0]  sync2_q;
	logic        wpend_q;
	logic        rpend_q;
	logic [9:0]  aaddr_q;

	// Address phase capture
	wire         a_valid = hsel && hready && (htrans == PPX_HTRANS_NONSEQ);
	wire         bad_size = (hsize != PPX_HSIZE_WORD);
	wire         on_page2 = (page_q == PPX_PAGE_EXT2); // R1
	wire         hit_page = (aaddr_q == PPX_ADDR_PAGE_SEL);
	wire         hit_trim = on_page2 && (aaddr_q == PPX_ADDR_TX_TRIM);
	wire         hit_eee  = on_page2 && (aaddr_q == PPX_ADDR_EEE_CTRL);
	wire         hit_mac  = on_page2 && (aaddr_q == PPX_ADDR_MAC_CTRL);
	wire         hit_srst = (aaddr_q == PPX_ADDR_SOFT_RST);
	wire [15:0]  wd       = hwdata[15:0];
	wire         soft_rst = wpend_q && hit_srst && hwdata[0];

	// Live status bits merged into the energy-saving register view
	wire [15:0]  eee_view = (eee_q & PPX_EEE_WMASK)
		| (16'h0001 << PPX_EEE_LINK_UP) & {16{sync2_q[0]}}
		| (16'h0001 << PPX_EEE_GIG_ON) & {16{sync2_q[1]}}
		| (16'h0001 << PPX_EEE_100_ON) & {16{sync2_q[2]}}; // R8

	wire [15:0]  rd_mux = hit_page ? page_q :
		hit_trim ? trim_q :
		hit_eee  ? eee_view :
		hit_mac  ? mac_q : 16'h0000;

	always_ff @(posedge clk) begin
		if (rst) begin
			wpend_q <= 1'b0;
			rpend_q <= 1'b0;
			aaddr_q <= 10'h000;
		end else if (ce) begin
			wpend_q <= a_valid && hwrite && !bad_size;
			rpend_q <= a_valid && !hwrite;
			if (a_valid) begin
				aaddr_q <= haddr[9:0];
			end
		end
	end

	// Read data registered in the data phase; reads take one wait state
	always_ff @(posedge clk) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (ce) begin
			hrdata <= a_valid && !hwrite ? 32'h0000_0000 : hrdata;
			if (rpend_q) begin
				hrdata <= {16'h0000, rd_mux};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (ce) begin
			hreadyout <= !(a_valid && !hwrite);
			hresp     <= 1'b0;
		end
	end

	// Page select: only the two documented codes are accepted
	always_ff @(posedge clk) begin
		if (rst) begin
			page_q <= PPX_PAGE_MAIN;
		end else if (ce && wpend_q && hit_page) begin
			if (wd == PPX_PAGE_EXT2 || wd == PPX_PAGE_MAIN) begin
				page_q <= wd; // R1
			end
		end
	end

	// Trim register: every field sticky, so only hardware reset restores it
	always_ff @(posedge clk) begin
		if (rst) begin
			trim_q <= PPX_TX_TRIM_RST; // R2 R3 R4 R5 R21
		end else if (ce && wpend_q && hit_trim) begin
			trim_q <= wd;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			eee_q <= PPX_EEE_RST; // R21
		end else if (ce && wpend_q && hit_eee) begin
			eee_q <= wd & PPX_EEE_WMASK;
		end
	end

	// Fast link drop bit is the one field a soft reset clears
	always_ff @(posedge clk) begin
		if (rst) begin
			mac_q <= PPX_MAC_RST;
		end else if (ce) begin
			if (wpend_q && hit_mac) begin
				mac_q <= wd & (PPX_MAC_STICKY | (16'h0001 << PPX_MAC_FLD_EN));
			end else if (soft_rst) begin
				mac_q <= mac_q & PPX_MAC_STICKY; // R16 R21
			end
		end
	end

	// Pin status synchronisers
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q <= 3'b000;
			sync2_q <= 3'b000;
		end else if (ce) begin
			sync1_q <= {fe_eee_in, gig_eee_in, link_up_in};
			sync2_q <= sync1_q;
		end
	end

	// LPI steering from the debug controls
	wire is_fe  = (speed_sel == 2'b01);
	wire is_gig = (speed_sel == 2'b10);
	wire tx_inh = (is_fe && eee_q[PPX_EEE_INH_100TX])
		|| (is_gig && eee_q[PPX_EEE_INH_GTX]); // R12 R14
	wire rx_inh = (is_fe && eee_q[PPX_EEE_INH_100RX])
		|| (is_gig && eee_q[PPX_EEE_INH_GRX]); // R13 R15
	wire force_lpi = eee_q[PPX_EEE_FORCE_LPI]; // R10
	wire tx_lpi_d  = force_lpi ? gen_lpi_ok : (mac_tx_lpi && !tx_inh);
	wire forced_gig = eee_q[PPX_EEE_FORCE_GIG]
		&& ({ctrl_speed_msb, ctrl_speed_lsb} == 2'b10); // R9
	wire [1:0] led_d = eee_q[PPX_EEE_LED_LSB +: 2] ^ ~led_raw; // R7

	always_ff @(posedge clk) begin
		if (rst) begin
			mdi_tx_lpi <= 1'b0;
		end else if (ce) begin
			mdi_tx_lpi <= tx_lpi_d; // R10 R12 R14
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mac_rx_lpi <= 1'b0;
		end else if (ce) begin
			mac_rx_lpi <= mdi_rx_lpi && !rx_inh; // R13 R15
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ignore_mac_tx <= 1'b0;
		end else if (ce) begin
			ignore_mac_tx <= force_lpi; // R10
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			force_gig_ok <= 1'b0;
		end else if (ce) begin
			force_gig_ok <= forced_gig; // R9
		end
	end

	// LEDs dark after reset: active-low pins idle high
	always_ff @(posedge clk) begin
		if (rst) begin
			led_pin <= 2'b11;
		end else if (ce) begin
			led_pin <= led_d; // R7
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			te_eee_mode <= 1'b0;
		end else if (ce) begin
			te_eee_mode <= eee_q[PPX_EEE_10E_EN]; // R6
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			copper_line_driver_gig_trim <= PPX_TX_TRIM_RST[PPX_TRIM_GIG_LSB +: 4];
		end else if (ce) begin
			copper_line_driver_gig_trim <= trim_q[PPX_TRIM_GIG_LSB +: 4]; // R2
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			copper_line_driver_fe_trim <= PPX_TX_TRIM_RST[PPX_TRIM_100_LSB +: 4];
		end else if (ce) begin
			copper_line_driver_fe_trim <= trim_q[PPX_TRIM_100_LSB +: 4]; // R3
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			copper_line_driver_te_trim <= PPX_TX_TRIM_RST[PPX_TRIM_10_LSB +: 4];
		end else if (ce) begin
			copper_line_driver_te_trim <= trim_q[PPX_TRIM_10_LSB +: 4]; // R4
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			copper_line_driver_tee_trim <= PPX_TX_TRIM_RST[PPX_TRIM_10E_LSB +: 4];
		end else if (ce) begin
			copper_line_driver_tee_trim <= trim_q[PPX_TRIM_10E_LSB +: 4]; // R5
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			fast_link_drop_alert_en <= 1'b0;
		end else if (ce) begin
			fast_link_drop_alert_en <= mac_q[PPX_MAC_FLD_EN]; // R16
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sof_ind_en <= 1'b0;
		end else if (ce) begin
			sof_ind_en <= mac_q[PPX_MAC_SOF_EN]; // R17
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rx_clk_dly <= 3'b000;
		end else if (ce) begin
			rx_clk_dly <= mac_q[PPX_MAC_RXDLY_LSB +: 3]; // R20
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_clk_dly <= 3'b000;
		end else if (ce) begin
			tx_clk_dly <= mac_q[PPX_MAC_TXDLY_LSB +: 3]; // R20
		end
	end

	// Forced LPI blanks MAC data so the line sees only the generator
	wire [7:0] tx_src = force_lpi ? 8'h00 : mac_txd;

	ppx_lane_rev u_rx_rev (
		.clk  (clk),
		.rst  (rst),
		.ce   (ce),
		.rev  (mac_q[PPX_MAC_RX_REV]), // R18
		.wide (mac_wide),
		.din  (line_rxd),
		.dout (mac_rxd)
	);

	ppx_lane_rev u_tx_rev (
		.clk  (clk),
		.rst  (rst),
		.ce   (ce),
		.rev  (mac_q[PPX_MAC_TX_REV]), // R19
		.wide (mac_wide),
		.din  (tx_src),
		.dout (line_txd)
	);

endmodule

`default_nettype wire

// File: src/ppx_pkg.sv
/*
 * Package for the page-2 transmit, energy-saving and MAC-interface control bank.
 * Holds byte addresses, field positions, reset values and the page-select codes.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package ppx_pkg;

	// Page-select register and register addresses (word index times four)
	localparam logic [7:0]  PPX_IDX_PAGE_SEL  = 8'h1F;
	localparam logic [7:0]  PPX_IDX_TX_TRIM   = 8'h10;
	localparam logic [7:0]  PPX_IDX_EEE_CTRL  = 8'h11;
	localparam logic [7:0]  PPX_IDX_MAC_CTRL  = 8'h14;
	localparam logic [7:0]  PPX_IDX_SOFT_RST  = 8'h20;
	localparam logic [9:0]  PPX_ADDR_PAGE_SEL = {PPX_IDX_PAGE_SEL, 2'b00};
	localparam logic [9:0]  PPX_ADDR_TX_TRIM  = {PPX_IDX_TX_TRIM, 2'b00};
	localparam logic [9:0]  PPX_ADDR_EEE_CTRL = {PPX_IDX_EEE_CTRL, 2'b00};
	localparam logic [9:0]  PPX_ADDR_MAC_CTRL = {PPX_IDX_MAC_CTRL, 2'b00};
	localparam logic [9:0]  PPX_ADDR_SOFT_RST = {PPX_IDX_SOFT_RST, 2'b00};

	localparam logic [15:0] PPX_PAGE_MAIN  = 16'h0000;
	localparam logic [15:0] PPX_PAGE_EXT2  = 16'h0002;

	// Transmit trim fields
	localparam int          PPX_TRIM_GIG_LSB  = 12;
	localparam int          PPX_TRIM_100_LSB  = 8;
	localparam int          PPX_TRIM_10_LSB   = 4;
	localparam int          PPX_TRIM_10E_LSB  = 0;
	localparam logic [15:0] PPX_TX_TRIM_RST   = 16'h028E;

	// Energy-saving control fields
	localparam int          PPX_EEE_10E_EN    = 15;
	localparam int          PPX_EEE_LED_LSB   = 10;
	localparam int          PPX_EEE_LINK_UP   = 8;
	localparam int          PPX_EEE_GIG_ON    = 7;
	localparam int          PPX_EEE_100_ON    = 6;
	localparam int          PPX_EEE_FORCE_GIG = 5;
	localparam int          PPX_EEE_FORCE_LPI = 4;
	localparam int          PPX_EEE_INH_100TX = 3;
	localparam int          PPX_EEE_INH_100RX = 2;
	localparam int          PPX_EEE_INH_GTX   = 1;
	localparam int          PPX_EEE_INH_GRX   = 0;
	localparam logic [15:0] PPX_EEE_WMASK     = 16'h8C3F;
	localparam logic [15:0] PPX_EEE_RST       = 16'h0000;

	// MAC-interface control fields
	localparam int          PPX_MAC_FLD_EN    = 15;
	localparam int          PPX_MAC_SOF_EN    = 12;
	localparam int          PPX_MAC_RX_REV    = 7;
	localparam int          PPX_MAC_RXDLY_LSB = 4;
	localparam int          PPX_MAC_TX_REV    = 3;
	localparam int          PPX_MAC_TXDLY_LSB = 0;
	localparam logic [15:0] PPX_MAC_STICKY    = 16'h10FF;
	localparam logic [15:0] PPX_MAC_RST       = 16'h0000;

	localparam logic [1:0]  PPX_HTRANS_NONSEQ = 2'b10;
	localparam logic [2:0]  PPX_HSIZE_WORD    = 3'b010;

endpackage

// File: src/ppx_lane_rev.sv
/*
 * Optional lane reversal of an 8-bit MAC data bus, registered.
 * In 4-bit mode only the low nibble is reversed; upper bits pass through.
 * Assumes all inputs are already on clk.
 */
`timescale 1ns/1ps
`default_nettype none

module ppx_lane_rev
	import ppx_pkg::*;
(
	input  wire logic       clk,       // Clock
	input  wire logic       rst,       // Sync reset
	input  wire logic       ce,        // Clock enable
	input  wire logic       rev,       // Reverse lanes
	input  wire logic       wide,      // 1: 8-bit bus, 0: 4-bit bus
	input  wire logic [7:0] din,       // Data in
	output logic      [7:0] dout       // Data out
);

	logic [7:0] rev8;
	logic [7:0] rev4;
	logic [7:0] sel;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_rev
			assign rev8[i] = din[7-i];
		end
		for (i = 0; i < 4; i++) begin : g_rev4
			assign rev4[i] = din[3-i];
		end
	endgenerate
	assign rev4[7:4] = din[7:4];
	assign sel = !rev ? din : (wide ? rev8 : rev4);

	always_ff @(posedge clk) begin
		if (rst) begin
			dout <= 8'h00;
		end else if (ce) begin
			dout <= sel;
		end
	end

endmodule

`default_nettype wire

// File: verif/ppx_chk_assertions.sv
/* Port checker for the page-2 control bank.
 * Bound to ppx_top; single clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none

module ppx_chk
	import ppx_pkg::*;
(
	input wire logic       clk,            // Clock
	input wire logic       rst,            // Reset
	input wire logic       ce,             // Enable
	input wire logic       hsel,           // Select
	input wire logic       hready,         // Bus ready
	input wire logic [1:0] htrans,         // Transfer
	input wire logic       hwrite,         // Write
	input wire logic       hreadyout,      // Slave ready
	input wire logic       hresp,          // Response
	input wire logic       mac_tx_lpi,     // MAC LPI
	input wire logic       gen_lpi_ok,     // Generator LPI
	input wire logic       mdi_rx_lpi,     // Line LPI
	input wire logic       ctrl_speed_msb, // Ctrl bit 6
	input wire logic       ctrl_speed_lsb, // Ctrl bit 13
	input wire logic       force_gig_ok,   // Forced gig
	input wire logic       mdi_tx_lpi,     // Line LPI out
	input wire logic       mac_rx_lpi,     // MAC LPI out
	input wire logic       ignore_mac_tx,  // Drop MAC data
	input wire logic       mac_wide,       // 8-bit lanes
	input wire logic [7:0] line_rxd,       // Line data
	input wire logic [7:0] mac_rxd,        // MAC data out
	input wire logic [7:0] line_txd        // Line data out
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_hresp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_read_wait: assert property (ce && hsel && hready && htrans == PPX_HTRANS_NONSEQ && !hwrite
		|=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
	a_tx_lpi_src: assert property ($past(ce) && mdi_tx_lpi
		|-> $past(mac_tx_lpi || gen_lpi_ok)) else $error("line LPI without cause");
	a_rx_lpi_src: assert property ($past(ce) && mac_rx_lpi
		|-> $past(mdi_rx_lpi)) else $error("MAC LPI without cause");
	a_force_gig_src: assert property ($past(ce) && force_gig_ok
		|-> $past(ctrl_speed_msb && !ctrl_speed_lsb)) else $error("forced gig bad");
	a_forced_lpi: assert property ($past(ce) && ignore_mac_tx
		|-> mdi_tx_lpi == $past(gen_lpi_ok)) else $error("forced LPI not followed");
	a_tx_data_drop: assert property (ignore_mac_tx && $past(ignore_mac_tx)
		|-> line_txd == 8'h00) else $error("MAC data not dropped");
	a_upper_pass: assert property ($past(ce) && !$past(rst) && !$past(mac_wide)
		|-> mac_rxd[7:4] == $past(line_rxd[7:4])) else $error("upper lanes changed");
endmodule

bind ppx_top ppx_chk u_chk (.clk, .rst, .ce, .hsel, .hready, .htrans, .hwrite, .hreadyout,
	.hresp, .mac_tx_lpi, .gen_lpi_ok, .mdi_rx_lpi, .ctrl_speed_msb, .ctrl_speed_lsb,
	.force_gig_ok, .mdi_tx_lpi, .mac_rx_lpi, .ignore_mac_tx, .mac_wide, .line_rxd,
	.mac_rxd, .line_txd);

`default_nettype wire

// File: verif/ppx_mac_model.sv
/* MAC and line data source.
 * Pattern moves each cycle while run is high, so stale lanes never match. */
`timescale 1ns/1ps
`default_nettype none

module ppx_mac_model (
	input  wire logic       clk,      // Clock
	input  wire logic       rst,      // Reset
	input  wire logic       run,      // Advance pattern
	output logic      [7:0] mac_txd,  // Transmit lanes
	output logic      [7:0] line_rxd  // Receive lanes
);
	logic [7:0] cnt_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= 8'h5A;
		end else if (run) begin
			cnt_q <= cnt_q + 8'h1D;
		end
	end
	assign mac_txd  = cnt_q;
	assign line_rxd = {cnt_q[3:0], ~cnt_q[7:4]};
endmodule

`default_nettype wire

// File: verif/phy_page2_tx_eee_mac_ctrl_test.sv
/* Self-checking bench for the page-2 control bank.
 * Drives AHB-Lite singles; hready is the slave's hreadyout. */
`timescale 1ns/1ps
`default_nettype none

module phy_page2_tx_eee_mac_ctrl_test import ppx_pkg::*;;
	typedef struct packed {logic [9:0] wa; logic [15:0] wd; logic [9:0] ra; logic [15:0] re;} ppx_row_t;
	localparam ppx_row_t ROWS [10] = '{
		'{PPX_ADDR_TX_TRIM, 16'h1234, PPX_ADDR_TX_TRIM, 16'h1234},
		'{PPX_ADDR_TX_TRIM, 16'hFEDC, PPX_ADDR_TX_TRIM, 16'hFEDC},
		'{PPX_ADDR_EEE_CTRL, 16'hFFFF, PPX_ADDR_EEE_CTRL, 16'h8C3F},
		'{PPX_ADDR_EEE_CTRL, 16'h0000, PPX_ADDR_EEE_CTRL, 16'h0000},
		'{PPX_ADDR_MAC_CTRL, 16'hFFFF, PPX_ADDR_MAC_CTRL, 16'h90FF},
		'{10'h048, 16'h5555, 10'h048, 16'h0000},
		'{PPX_ADDR_PAGE_SEL, 16'h0001, PPX_ADDR_MAC_CTRL, 16'h90FF},
		'{PPX_ADDR_PAGE_SEL, PPX_PAGE_MAIN, PPX_ADDR_TX_TRIM, 16'h0000},
		'{PPX_ADDR_TX_TRIM, 16'h1111, PPX_ADDR_MAC_CTRL, 16'h0000},
		'{PPX_ADDR_PAGE_SEL, PPX_PAGE_EXT2, PPX_ADDR_TX_TRIM, 16'hFEDC}};
	logic        clk = 0, rst = 1, ce = 1, hsel = 0, hwrite = 0, run = 1, mac_wide = 0;
	logic        link_up_in = 0, gig_eee_in = 0, fe_eee_in = 0, mac_tx_lpi = 0;
	logic        mdi_rx_lpi = 0, gen_lpi_ok = 0, ctrl_speed_msb = 0, ctrl_speed_lsb = 0;
	logic        hready, hreadyout, hresp, te_eee_mode, force_gig_ok, mdi_tx_lpi, mac_rx_lpi;
	logic        ignore_mac_tx, fast_link_drop_alert_en, sof_ind_en;
	logic        tx_inh_exp, rx_inh_exp;
	logic [1:0]  htrans = 0, speed_sel = 0, led_raw = 0, led_pin;
	logic [2:0]  hsize = PPX_HSIZE_WORD, rx_clk_dly, tx_clk_dly;
	logic [3:0]  copper_line_driver_gig_trim, copper_line_driver_fe_trim;
	logic [3:0]  copper_line_driver_te_trim, copper_line_driver_tee_trim;
	logic [7:0]  mac_txd, line_rxd, mac_rxd, line_txd, mac_out;
	logic [15:0] trims;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	int          num_errors = 0, checks = 0;

	assign hready  = hreadyout;
	assign trims   = {copper_line_driver_gig_trim, copper_line_driver_fe_trim,
		copper_line_driver_te_trim, copper_line_driver_tee_trim};
	assign mac_out = {fast_link_drop_alert_en, sof_ind_en, rx_clk_dly, tx_clk_dly};
	always #12.5 clk = ~clk;

	ppx_top i_dut (.clk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hrdata, .hreadyout, .hresp, .link_up_in, .gig_eee_in, .fe_eee_in, .speed_sel,
		.mac_wide, .mac_tx_lpi, .mdi_rx_lpi, .mac_txd, .line_rxd, .gen_lpi_ok, .led_raw,
		.ctrl_speed_msb, .ctrl_speed_lsb, .copper_line_driver_gig_trim,
		.copper_line_driver_fe_trim, .copper_line_driver_te_trim, .copper_line_driver_tee_trim,
		.te_eee_mode, .led_pin, .force_gig_ok, .mdi_tx_lpi, .mac_rx_lpi, .ignore_mac_tx,
		.fast_link_drop_alert_en, .sof_ind_en, .rx_clk_dly, .tx_clk_dly, .mac_rxd, .line_txd);
	ppx_mac_model i_mac (.clk, .rst, .run, .mac_txd, .line_rxd);

	task automatic results();
		if (num_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask

	// Bounded wait for one sampled-high hreadyout edge
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			results();
		end
	endtask

	task automatic bus(input logic w, input logic [9:0] a, input logic [15:0] d);
		hsel   <= 1'b1;
		htrans <= PPX_HTRANS_NONSEQ;
		haddr  <= {22'h0, a};
		hwrite <= w;
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {16'h0, d};
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic rchk(input string n, input logic [9:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0);
		chk(n, {16'h0, e}, rd);
	endtask

	function automatic logic [7:0] flip(input logic [7:0] x, input logic w);
		logic [7:0] r;
		r = {<<{x}};
		return w ? r : {x[7:4], r[7:4]};
	endfunction

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		bus(1'b1, PPX_ADDR_PAGE_SEL, PPX_PAGE_EXT2);
		foreach (ROWS[i]) begin
			bus(1'b1, ROWS[i].wa, ROWS[i].wd);
			rchk("row read", ROWS[i].ra, ROWS[i].re);
		end
		chk("trims", 32'hFEDC, {16'h0, trims});
		link_up_in <= 1'b1;
		gig_eee_in <= 1'b1;
		repeat (4) @(posedge clk);
		rchk("status", PPX_ADDR_EEE_CTRL, 16'h0180);
		link_up_in <= 1'b0;
		gig_eee_in <= 1'b0;
		fe_eee_in  <= 1'b1;
		repeat (4) @(posedge clk);
		rchk("status", PPX_ADDR_EEE_CTRL, 16'h0040);
		mac_tx_lpi <= 1'b1;
		mdi_rx_lpi <= 1'b1;
		// 10M pass included: no inhibit bit may bite at that speed
		for (int s = 0; s < 3; s++) begin
			speed_sel <= s[1:0];
			for (int k = 0; k < 16; k++) begin
				bus(1'b1, PPX_ADDR_EEE_CTRL, k[15:0]);
				repeat (2) @(posedge clk);
				tx_inh_exp = s == 1 ? k[3] : (s == 2 && k[1]);
				rx_inh_exp = s == 1 ? k[2] : (s == 2 && k[0]);
				chk("tx lpi", {31'h0, !tx_inh_exp}, {31'h0, mdi_tx_lpi});
				chk("rx lpi", {31'h0, !rx_inh_exp}, {31'h0, mac_rx_lpi});
			end
		end
		gen_lpi_ok     <= 1'b1;
		mac_tx_lpi     <= 1'b0;
		led_raw        <= 2'b01;
		ctrl_speed_msb <= 1'b1;
		bus(1'b1, PPX_ADDR_EEE_CTRL, 16'h8C30);
		repeat (2) @(posedge clk);
		chk("forced lpi", 32'h3, {30'h0, mdi_tx_lpi, ignore_mac_tx});
		chk("line txd", 32'h0, {24'h0, line_txd});
		chk("eee mode", 32'h1, {31'h0, te_eee_mode});
		chk("led", 32'h1, {30'h0, led_pin});
		chk("force gig", 32'h1, {31'h0, force_gig_ok});
		ctrl_speed_lsb <= 1'b1;
		repeat (2) @(posedge clk);
		chk("force gig", 32'h0, {31'h0, force_gig_ok});
		// Debug bits back off before normal traffic
		bus(1'b1, PPX_ADDR_EEE_CTRL, 16'h0000);
		bus(1'b1, PPX_ADDR_MAC_CTRL, 16'h90DB);
		run <= 1'b0;
		for (int w = 0; w < 2; w++) begin
			mac_wide <= w[0];
			repeat (3) @(posedge clk);
			chk("rxd", {24'h0, flip(line_rxd, w[0])}, {24'h0, mac_rxd});
			chk("txd", {24'h0, flip(mac_txd, w[0])}, {24'h0, line_txd});
		end
		chk("mac out", 32'hEB, {24'h0, mac_out});
		bus(1'b1, PPX_ADDR_SOFT_RST, 16'h0001);
		rchk("soft rst", PPX_ADDR_MAC_CTRL, 16'h10DB);
		chk("trims", 32'hFEDC, {16'h0, trims});
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("trim rst", 32'h028E, {16'h0, trims});
		chk("mac rst", 32'h0, {24'h0, mac_out});
		bus(1'b1, PPX_ADDR_PAGE_SEL, PPX_PAGE_EXT2);
		rchk("mac rst", PPX_ADDR_MAC_CTRL, 16'h0000);
		results();
	end
endmodule

`default_nettype wire
